// >>> identity_rom_access_regs.sv
// Version and identity ROM access registers with byte read sequencer.
// Assumes an EEPROM engine on clk_in that answers each request with one
// ack pulse carrying the byte; the presence strap is an asynchronous pin.
`include "identity_rom_access_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module identity_rom_access_regs #(
  parameter int          AW        = 8,
  parameter int          BIB_BYTES = `BIB_BYTES_DEF,
  parameter logic [7:0]  MAJOR_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0]  MINOR_CODE = 8'ha5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Register port
  input  wire logic [7:0]        addr_in,
  input  wire logic [31:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [31:0]            rdata_out,
  // EEPROM engine
  input  wire logic              rom_present_in,
  output logic                   rom_req_out,
  output logic [AW-1:0]          rom_addr_out,
  input  wire logic              rom_ack_in,
  input  wire identity_rom_access_pkg::byte_t rom_data_in,
  // Node information load
  output identity_rom_access_pkg::byte_t    node_info_byte_out,
  output logic [AW-1:0]          node_info_idx_out,
  output logic                   node_info_valid_out,
  output logic                   node_info_done_out
);
  import identity_rom_access_pkg::*;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic rst_meta_r;
  logic rst_n;
  logic pres_meta_r;
  logic pres_sync_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Strap may change at any time, so it is only read after two flops
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pres_meta_r <= 1'b0;
      pres_sync_r <= 1'b0;
    end else begin
      pres_meta_r <= rom_present_in;
      pres_sync_r <= pres_meta_r;
    end
  end

  // ****************************************
  // State
  // ****************************************
  ctl_state_t     state_r;
  ctl_state_t     state_nxt;
  logic [1:0]     settle_r;
  logic [1:0]     settle_nxt;
  logic           present_r;
  logic           present_nxt;
  logic [AW-1:0]  ptr_r;
  logic [AW-1:0]  ptr_nxt;
  logic [AW-1:0]  load_r;
  logic [AW-1:0]  load_nxt;
  logic           clear_r;
  logic           clear_nxt;
  logic           fetch_r;
  logic           fetch_nxt;
  byte_t          fetched_byte_r;
  byte_t          fetched_byte_nxt;
  byte_t          opt_ofs_r;
  byte_t          opt_ofs_nxt;
  logic           req_r;
  logic           req_nxt;
  logic [AW-1:0]  raddr_r;
  logic [AW-1:0]  raddr_nxt;
  byte_t          nib_r;
  byte_t          nib_nxt;
  logic [AW-1:0]  nidx_r;
  logic [AW-1:0]  nidx_nxt;
  logic           nval_r;
  logic           nval_nxt;
  logic           ndone_r;
  logic           ndone_nxt;
  logic [31:0]    rdata_r;
  logic [31:0]    rdata_nxt;

  // ****************************************
  // Register decode
  // ****************************************
  wire logic        ver_sel   = (addr_in == `VER_REG_OFS);
  wire logic        rom_sel   = (addr_in == `ROM_REG_OFS);
  wire logic        rom_wr    = wr_in && rom_sel;
  wire logic        set_clear = rom_wr && wdata_in[`ROM_CLEAR_BIT];
  wire logic        set_fetch = rom_wr && wdata_in[`ROM_FETCH_BIT];
  wire logic        last_load = (load_r == AW'(BIB_BYTES - 1));
  wire logic        opt_hit   = (rom_addr_out == AW'(`OPT_FLAG_ADDR));
  wire byte_t       opt_val   = rom_data_in[`OPT_FLAG_BIT] ? `OPT_IMAGE_OFS
                                                           : `OPT_NONE;

  // Version: zeros around fixed codes and the presence flag
  wire logic [31:0] ver_word  = {7'h00, present_r, MAJOR_CODE,
                                 8'h00, MINOR_CODE};
  // Access: command bits read back as pending, reserved bits zero
  wire logic [31:0] rom_word  = {clear_r, 5'h00, fetch_r, 1'b0,
                                 fetched_byte_r, 8'h00, opt_ofs_r};

  // Unmapped offsets read zero; writes to read-only bits are dropped
  wire logic [31:0] rd_mux    = ver_sel ? ver_word :
                                rom_sel ? rom_word : 32'h0000_0000;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt        = state_r;
    settle_nxt       = settle_r;
    present_nxt      = pres_sync_r;
    ptr_nxt          = ptr_r;
    load_nxt         = load_r;
    clear_nxt        = clear_r | set_clear;
    fetch_nxt        = fetch_r | set_fetch;
    fetched_byte_nxt = fetched_byte_r;
    opt_ofs_nxt      = opt_ofs_r;
    req_nxt          = req_r;
    raddr_nxt        = raddr_r;
    nib_nxt          = nib_r;
    nidx_nxt         = nidx_r;
    nval_nxt         = 1'b0;
    ndone_nxt        = ndone_r;
    rdata_nxt        = rd_in ? rd_mux : 32'h0000_0000;
    case (state_r)
      // Let the strap synchroniser fill before deciding on autoload
      ST_SETTLE: begin
        settle_nxt = settle_r + 2'h1;
        if (settle_r == `SETTLE_CYCLES) begin
          if (pres_sync_r) begin
            state_nxt = ST_AUTO_REQ;
            req_nxt   = 1'b1;
            raddr_nxt = '0;
          end else begin
            state_nxt = ST_IDLE;
            ndone_nxt = 1'b1;
          end
        end
      end
      ST_AUTO_REQ: begin
        if (rom_ack_in) begin
          nib_nxt  = rom_data_in;
          nidx_nxt = load_r;
          nval_nxt = 1'b1;
          if (opt_hit) begin
            opt_ofs_nxt = opt_val;
          end
          if (last_load) begin
            req_nxt   = 1'b0;
            ndone_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            load_nxt  = load_r + AW'(1);
            raddr_nxt = load_r + AW'(1);
          end
        end
      end
      // Commands wait here until any transfer in flight has ended
      ST_IDLE: begin
        if (clear_r) begin
          ptr_nxt   = '0;
          clear_nxt = set_clear;
        end else if (fetch_r) begin
          req_nxt   = 1'b1;
          raddr_nxt = ptr_r;
          state_nxt = ST_SW_REQ;
        end
      end
      ST_SW_REQ: begin
        if (rom_ack_in) begin
          fetched_byte_nxt = rom_data_in;
          if (opt_hit) begin
            opt_ofs_nxt = opt_val;
          end
          ptr_nxt   = ptr_r + AW'(1);
          fetch_nxt = set_fetch;
          req_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        req_nxt   = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= ST_SETTLE;
      settle_r       <= 2'h0;
      present_r      <= 1'b0;
      ptr_r          <= '0;
      load_r         <= '0;
      clear_r        <= 1'b0;
      fetch_r        <= 1'b0;
      fetched_byte_r <= 8'h00;
      opt_ofs_r      <= `OPT_NONE;
    end else begin
      state_r        <= state_nxt;
      settle_r       <= settle_nxt;
      present_r      <= present_nxt;
      ptr_r          <= ptr_nxt;
      load_r         <= load_nxt;
      clear_r        <= clear_nxt;
      fetch_r        <= fetch_nxt;
      fetched_byte_r <= fetched_byte_nxt;
      opt_ofs_r      <= opt_ofs_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      req_r   <= 1'b0;
      raddr_r <= '0;
      nib_r   <= 8'h00;
      nidx_r  <= '0;
      nval_r  <= 1'b0;
      ndone_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      req_r   <= req_nxt;
      raddr_r <= raddr_nxt;
      nib_r   <= nib_nxt;
      nidx_r  <= nidx_nxt;
      nval_r  <= nval_nxt;
      ndone_r <= ndone_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_out           = rdata_r;
  assign rom_req_out         = req_r;
  assign rom_addr_out        = raddr_r;
  assign node_info_byte_out  = nib_r;
  assign node_info_idx_out   = nidx_r;
  assign node_info_valid_out = nval_r;
  assign node_info_done_out  = ndone_r;

endmodule

`default_nettype wire

// >>> identity_rom_access_consts.svh
// Constants for the interface version and identity ROM access registers.
// Assumes one 125 MHz clock and a byte-wide EEPROM read engine beside it.
//
// Overview of operation
// - Reserved bits read zero, ignore writes
// - Version bit 24 shows EEPROM detected
// - Present EEPROM autoloads node info after reset
// - Version bits 23:16 hold fixed major code
// - Version bits 7:0 hold fixed minor code
// - Bit 31 zeroes pointer, self-clears after
// - Pointer clear fetches no byte itself
// - Bit 25 starts read of addressed byte
// - Bit 25 self-clears when read completes
// - Fetched byte lands in bits 23:16
// - Option offset field reads zero by default
// - Byte 6 bit 5 set gives 20h
`ifndef IDENT_ROM_CONSTS_SVH
`define IDENT_ROM_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define VER_REG_OFS       8'h00
`define ROM_REG_OFS       8'h04

// ****************************************
// Field positions
// ****************************************
`define VER_PRESENT_BIT   24
`define ROM_CLEAR_BIT     31
`define ROM_FETCH_BIT     25
`define OPT_FLAG_BIT      5

// ****************************************
// Values
// ****************************************
`define OPT_FLAG_ADDR     8'h06
`define OPT_IMAGE_OFS     8'h20
`define OPT_NONE          8'h00
`define BIB_BYTES_DEF     20
`define SETTLE_CYCLES     2'h3

`endif

// >>> identity_rom_access_pkg.sv
// Types shared by the identity ROM access block.
// Assumes the constants header is included by the design file.
package identity_rom_access_pkg;

  // Control sequencer states
  typedef enum logic [2:0] {
    ST_SETTLE   = 3'b000,
    ST_AUTO_REQ = 3'b001,
    ST_IDLE     = 3'b010,
    ST_SW_REQ   = 3'b011
  } ctl_state_t;

  typedef logic [7:0] byte_t;

endpackage

// >>> identity_rom_access_regs_monitor.sv
// Checker for the version and identity ROM register block.
// Assumes binding to identity_rom_access_regs; reads its ports only.
`timescale 1ns/10ps
`default_nettype none
module identity_rom_access_regs_monitor #(
  parameter int         AW         = 8,
  parameter int         BIB_BYTES  = 20,
  parameter logic [7:0] MAJOR_CODE = 8'h00,
  parameter logic [7:0] MINOR_CODE = 8'h00
) (
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  input wire logic [7:0]          addr_in,
  input wire logic                rd_in,
  input wire logic [31:0]         rdata_out,
  input wire logic                rom_req_out,
  input wire logic [AW-1:0]       rom_addr_out,
  input wire logic                rom_ack_in,
  input wire identity_rom_access_pkg::byte_t rom_data_in,
  input wire identity_rom_access_pkg::byte_t node_info_byte_out,
  input wire logic [AW-1:0]       node_info_idx_out,
  input wire logic                node_info_done_out,
  input wire logic                node_info_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_ack; rom_req_out && rom_ack_in; endsequence
  sequence s_auto; s_ack ##0 !node_info_done_out; endsequence
  property p_rsv; rd_in |=> rdata_out[30:26] == 5'h00 && rdata_out[15:8] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_quiet; !rd_in |=> rdata_out == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside slot");
  property p_ver;
    rd_in && addr_in == 8'h00 |=> rdata_out[31:25] == 7'h00
      && rdata_out[23:16] == MAJOR_CODE && rdata_out[15:0] == {8'h00, MINOR_CODE};
  endproperty
  a_ver: assert property (p_ver) else $error("version codes wrong");
  property p_opt;
    rd_in && addr_in == 8'h04 |=> !rdata_out[24] && rdata_out[7:0] inside {8'h00, 8'h20};
  endproperty
  a_opt: assert property (p_opt) else $error("option offset wrong");
  property p_hold; rom_req_out && !rom_ack_in |=> rom_req_out && $stable(rom_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_load;
    s_auto |=> node_info_valid_out && node_info_byte_out == $past(rom_data_in)
      && node_info_idx_out == $past(rom_addr_out);
  endproperty
  a_load: assert property (p_load) else $error("autoload byte lost");
  property p_last;
    s_auto ##0 rom_addr_out == BIB_BYTES - 1 |=> node_info_done_out && !rom_req_out;
  endproperty
  a_last: assert property (p_last) else $error("autoload end wrong");
  property p_sw; s_ack ##0 node_info_done_out |=> !rom_req_out; endproperty
  a_sw: assert property (p_sw) else $error("fetch not finished");
endmodule
bind identity_rom_access_regs identity_rom_access_regs_monitor #(.AW(AW), .BIB_BYTES(BIB_BYTES),
  .MAJOR_CODE(MAJOR_CODE), .MINOR_CODE(MINOR_CODE)) identity_rom_access_regs_monitor_i (
  .clk_in, .arst_n_in, .addr_in, .rd_in, .rdata_out, .rom_req_out, .rom_addr_out,
  .rom_ack_in, .rom_data_in, .node_info_byte_out, .node_info_idx_out,
  .node_info_done_out, .node_info_valid_out);
`default_nettype wire

// >>> eeprom_model.sv
// EEPROM model serving byte reads for the identity ROM block.
// Assumes request and address hold until the one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module eeprom_model (
  input  wire logic       clk_in,
  input  wire logic       req_in,
  input  wire logic [7:0] addr_in,
  input  wire logic       opt_in,
  output logic            ack_out,
  output logic [7:0]      data_out
);
  logic [3:0] cnt_r;
  // Byte 6 bit 5 flags an option image
  function automatic logic [7:0] rom_byte(input logic [7:0] a);
    return (a == 8'h06) ? {2'b01, opt_in, 5'h0c} : a ^ 8'h5c;
  endfunction
  initial begin
    cnt_r = 4'h0;
    ack_out = 1'b0;
    data_out = 8'h00;
  end
  // Latency varies with address so prompt and slow answers both occur
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    data_out <= ~data_out; // Data inverts each cycle outside the ack cycle
    if (req_in && !ack_out) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == (addr_in[3:0] ^ 4'h5)) begin
        ack_out <= 1'b1;
        data_out <= rom_byte(addr_in);
        cnt_r <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_identity_rom_access_regs.sv
// Bench for the version and identity ROM registers over the plain port.
// Assumes the EEPROM model answers every request the block raises.
`timescale 1ns/10ps
`default_nettype none
module test_identity_rom_access_regs;
  localparam logic [7:0] MAJ = 8'h3c; // Arbitrary value
  localparam logic [7:0] MIN = 8'hc3; // Arbitrary value
  logic        clk_in    = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        pres      = 1'b1;
  logic        opt       = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] rdata, v, exp;
  logic        req, ack, valid, done;
  logic [7:0]  raddr, rbyte, nbyte, nidx;
  int          miscompares = 0;
  int          check_count = 0;
  int          nload = 0;
  identity_rom_access_regs #(.BIB_BYTES(4), .MAJOR_CODE(MAJ), .MINOR_CODE(MIN)) identity_rom_access_regs_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rom_present_in(pres),
    .rom_req_out(req), .rom_addr_out(raddr), .rom_ack_in(ack), .rom_data_in(rbyte),
    .node_info_byte_out(nbyte), .node_info_idx_out(nidx),
    .node_info_valid_out(valid), .node_info_done_out(done));
  eeprom_model eeprom_model_i (.clk_in(clk_in), .req_in(req), .addr_in(raddr),
    .opt_in(opt), .ack_out(ack), .data_out(rbyte));
  initial forever #4 clk_in = ~clk_in;
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic stall();
    miscompares++;
    print_verdict();
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Poll the trigger bit; the bound stops a hung fetch
  task automatic fwait();
    v = 32'h0200_0000;
    for (int i = 0; i < 40 && v[25] !== 1'b0; i++) rd32(8'h04);
    if (v[25] !== 1'b0) stall();
  endtask
  task automatic do_reset();
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk_in);
    if (done !== 1'b1) stall();
    // Last load pulse shares its edge with done; let it be counted first
    @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    if (valid === 1'b1) begin
      cmp("node byte", eeprom_model_i.rom_byte(nidx), nbyte);
      cmp("node idx", nload, {24'h00_0000, nidx});
      nload++;
    end
  end
  initial begin
    do_reset();
    cmp("loads", 32'd4, nload);
    rd32(8'h00);
    cmp("version", {7'h00, 1'b1, MAJ, 8'h00, MIN}, v);
    wr32(8'h00, 32'hffff_ffff);
    rd32(8'h00);
    cmp("version ro", {7'h00, 1'b1, MAJ, 8'h00, MIN}, v);
    rd32(8'h08);
    cmp("unmapped", 32'h0, v);
    wr32(8'h04, 32'h80ff_ffff);
    rd32(8'h04);
    cmp("cleared", 32'h0, v & 32'hff00_ffff);
    for (int i = 0; i < 8; i++) begin
      wr32(8'h04, 32'h0200_0000);
      fwait();
      exp = {8'h00, eeprom_model_i.rom_byte(8'(i)), 16'h0000};
      exp[5] = (i > 5);
      cmp("fetch", exp, v);
    end
    wr32(8'h04, 32'h8000_0000);
    repeat (8) @(posedge clk_in);
    rd32(8'h04);
    cmp("clear only", exp, v);
    wr32(8'h04, 32'h8200_0000);
    wr32(8'h04, 32'h0000_0000);
    fwait();
    exp[23:16] = eeprom_model_i.rom_byte(8'h00);
    cmp("clear fetch", exp, v);
    @(posedge clk_in);
    opt <= 1'b0;
    for (int i = 1; i < 7; i++) begin
      wr32(8'h04, 32'h0200_0000);
      fwait();
    end
    exp = {8'h00, eeprom_model_i.rom_byte(8'h06), 16'h0000};
    cmp("option clear", exp, v);
    @(posedge clk_in);
    pres <= 1'b0;
    do_reset();
    cmp("no load", 32'd4, nload);
    rd32(8'h00);
    cmp("absent", {8'h00, MAJ, 8'h00, MIN}, v);
    rd32(8'h04);
    cmp("rom reset", 32'h0, v);
    print_verdict();
  end
endmodule
`default_nettype wire
